/* File: rtl/cbt_pkg.sv */
package cbt_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CFG_ONE = 4'h0;
  localparam logic [3:0] ADDR_CFG_TWO = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;

  // values after reset
  localparam logic [15:0] CFG_ONE_RST = 16'h0000;
  localparam logic [15:0] CFG_TWO_RST = 16'h0000;

  // field positions, first configuration register
  localparam int PRESC_LSB = 0;
  localparam int PRESC_MSB = 5;
  localparam int JW_LSB    = 6;
  localparam int JW_MSB    = 7;

  // field positions, second configuration register
  localparam int PROP_LSB   = 0;
  localparam int PROP_MSB   = 2;
  localparam int PH1_LSB    = 3;
  localparam int PH1_MSB    = 5;
  localparam int TRIPLE_BIT = 6;
  localparam int PH2SEL_BIT = 7;
  localparam int PH2_LSB    = 8;
  localparam int PH2_MSB    = 10;

  // information processing time in quanta
  localparam logic [3:0] PROC_TIME_TQ = 4'h2;

  // segment of the nominal bit, gray along the usual path
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1  = 2'b11,
    SEG_PH2  = 2'b10
  } cbt_seg_t;

  typedef struct packed {
    logic [5:0] baud_prescale;
    logic [1:0] jump_width;
    logic [2:0] prop_segment_len;
    logic [2:0] phase1_len;
    logic       triple_sample_sel;
    logic       phase2_prog;
    logic [2:0] phase2_len;
  } cbt_cfg_t;

  typedef struct packed {
    logic sample_bit;
    logic sample_strobe;
    logic bit_start;
    logic hard_sync;
    logic resync;
  } cbt_event_t;

endpackage

/* File: rtl/cbt_bit_timing.sv */
`timescale 1ns/1ns
// Functional notes
// - prescaler 1..64 then fixed divide by two
// - quantum equals 2*(prescale+1) input clocks
// - propagation segment 1..8 quanta, bits 2:0
// - phase1 1..8 quanta, bits 5:3
// - phase2 programmed, or max(phase1, 2)
// - bus sampled at end of phase1
// - triple mode: majority, half-quantum spacing
// - bit 6 selects triple or single sampling
// - edge position adjusts phase1 and phase2
// - idle falling edge restarts bit at sync
// - no resync in hard-synced bit
// - resync bounded by jump width
// - jump width 1..4 quanta, bits 7:6
module cbt_bit_timing (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // bus side
  input  wire logic              can_rx,
  input  wire logic              bus_idle,
  // bit events
  output cbt_pkg::cbt_event_t    bit_event
);

  logic [15:0]         cfg_one_reg;
  logic [15:0]         cfg_two_reg;
  logic [15:0]         rdata_reg;
  cbt_pkg::cbt_cfg_t   cfg;
  cbt_pkg::cbt_seg_t   state_reg;
  cbt_pkg::cbt_event_t ev_reg;
  logic [5:0]          presc_cnt_reg;
  logic                half_phase_reg;
  logic [4:0]          tq_cnt_reg;
  logic [3:0]          ext_reg;
  logic [3:0]          shr_reg;
  logic                hs_done_reg;
  logic                rs_done_reg;
  logic                rx_prev_reg;
  logic [1:0]          hist_reg;
  logic [3:0]          prop_len;
  logic [3:0]          ph1_len;
  logic [3:0]          ph2_len;
  logic [3:0]          jw_len;
  logic [4:0]          ph1_total;
  logic [4:0]          ph2_total;
  logic [4:0]          late_err;
  logic [4:0]          early_rem;
  logic                half_tick;
  logic                tq_tick;
  logic                fall_edge;
  logic                hard_sync_now;
  logic                resync_ok;
  logic                early_restart;
  logic                do_late;
  logic                do_short;
  logic                restart;
  logic                prop_end;
  logic                ph1_end;
  logic                ph2_end;
  logic                sample_evt;
  logic                bit_end;
  logic                sample_val;

  // configuration decode
  always_comb begin
    cfg.baud_prescale     = cfg_one_reg[cbt_pkg::PRESC_MSB:cbt_pkg::PRESC_LSB];
    cfg.jump_width        = cfg_one_reg[cbt_pkg::JW_MSB:cbt_pkg::JW_LSB];
    cfg.prop_segment_len  = cfg_two_reg[cbt_pkg::PROP_MSB:cbt_pkg::PROP_LSB];
    cfg.phase1_len        = cfg_two_reg[cbt_pkg::PH1_MSB:cbt_pkg::PH1_LSB];
    cfg.triple_sample_sel = cfg_two_reg[cbt_pkg::TRIPLE_BIT];
    cfg.phase2_prog       = cfg_two_reg[cbt_pkg::PH2SEL_BIT];
    cfg.phase2_len        = cfg_two_reg[cbt_pkg::PH2_MSB:cbt_pkg::PH2_LSB];
  end

  // segment lengths in quanta, field plus one
  always_comb begin
    prop_len = {1'b0, cfg.prop_segment_len} + 4'h1;
    ph1_len  = {1'b0, cfg.phase1_len} + 4'h1;
    jw_len   = {2'b00, cfg.jump_width} + 4'h1;
    if (cfg.phase2_prog) begin
      ph2_len = {1'b0, cfg.phase2_len} + 4'h1;
    end else if (ph1_len > cbt_pkg::PROC_TIME_TQ) begin
      ph2_len = ph1_len;
    end else begin
      ph2_len = cbt_pkg::PROC_TIME_TQ;
    end
    ph1_total = {1'b0, ph1_len} + {1'b0, ext_reg};
    // guard keeps phase2 at one quantum if jump width was set too large
    if (shr_reg >= ph2_len) begin
      ph2_total = 5'h01;
    end else begin
      ph2_total = {1'b0, ph2_len} - {1'b0, shr_reg};
    end
  end

  // quantum generation
  assign half_tick = (presc_cnt_reg >= cfg.baud_prescale) && !restart;
  assign tq_tick   = half_tick && half_phase_reg;

  // edge handling; recessive is high
  assign fall_edge     = rx_prev_reg && !can_rx;
  assign hard_sync_now = fall_edge && bus_idle;
  assign resync_ok     = fall_edge && !bus_idle && !hs_done_reg && !rs_done_reg;

  // phase error from where the edge falls in the bit
  always_comb begin
    if (state_reg == cbt_pkg::SEG_PROP) begin
      late_err = tq_cnt_reg + 5'h01;
    end else begin
      late_err = {1'b0, prop_len} + tq_cnt_reg + 5'h01;
    end
    early_rem = ph2_total - tq_cnt_reg;
  end

  assign early_restart = resync_ok && (state_reg == cbt_pkg::SEG_PH2)
                         && (early_rem <= {1'b0, jw_len});
  assign do_late       = resync_ok && ((state_reg == cbt_pkg::SEG_PROP)
                         || (state_reg == cbt_pkg::SEG_PH1));
  assign do_short      = resync_ok && (state_reg == cbt_pkg::SEG_PH2) && !early_restart;
  assign restart       = hard_sync_now || early_restart;

  assign prop_end   = tq_cnt_reg == ({1'b0, prop_len} - 5'h01);
  assign ph1_end    = tq_cnt_reg == (ph1_total - 5'h01);
  assign ph2_end    = tq_cnt_reg >= (ph2_total - 5'h01);
  assign sample_evt = tq_tick && (state_reg == cbt_pkg::SEG_PH1) && ph1_end;
  assign bit_end    = tq_tick && (state_reg == cbt_pkg::SEG_PH2) && ph2_end;

  // majority of current level and the two half-quantum samples before it
  always_comb begin
    if (cfg.triple_sample_sel) begin
      sample_val = (can_rx & hist_reg[0]) | (can_rx & hist_reg[1]) | (hist_reg[0] & hist_reg[1]);
    end else begin
      sample_val = can_rx;
    end
  end

  // register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_one_reg <= cbt_pkg::CFG_ONE_RST;
      cfg_two_reg <= cbt_pkg::CFG_TWO_RST;
    end else if (reg_wr) begin
      if (reg_addr == cbt_pkg::ADDR_CFG_ONE) begin
        cfg_one_reg <= {8'h00, reg_wdata[7:0]};
      end else if (reg_addr == cbt_pkg::ADDR_CFG_TWO) begin
        cfg_two_reg <= {5'h00, reg_wdata[10:0]};
      end
    end
  end

  // register reads, data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == cbt_pkg::ADDR_CFG_ONE) begin
        rdata_reg <= cfg_one_reg;
      end else if (reg_addr == cbt_pkg::ADDR_CFG_TWO) begin
        rdata_reg <= cfg_two_reg;
      end else if (reg_addr == cbt_pkg::ADDR_STATUS) begin
        rdata_reg <= {3'h0, tq_cnt_reg, 2'h0, rs_done_reg, hs_done_reg, state_reg, ev_reg.sample_bit, rx_prev_reg};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // prescaler; a restart realigns it so the sync quantum is whole
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_cnt_reg  <= 6'h00;
      half_phase_reg <= 1'b0;
    end else if (restart) begin
      presc_cnt_reg  <= 6'h00;
      half_phase_reg <= 1'b0;
    end else if (half_tick) begin
      presc_cnt_reg  <= 6'h00;
      half_phase_reg <= ~half_phase_reg;
    end else begin
      presc_cnt_reg  <= presc_cnt_reg + 6'h01;
    end
  end

  // segment sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg  <= cbt_pkg::SEG_SYNC;
      tq_cnt_reg <= 5'h00;
    end else if (restart) begin
      state_reg  <= cbt_pkg::SEG_SYNC;
      tq_cnt_reg <= 5'h00;
    end else if (tq_tick) begin
      case (state_reg)
        cbt_pkg::SEG_SYNC: begin
          state_reg  <= cbt_pkg::SEG_PROP;
          tq_cnt_reg <= 5'h00;
        end
        cbt_pkg::SEG_PROP: begin
          if (prop_end) begin
            state_reg  <= cbt_pkg::SEG_PH1;
            tq_cnt_reg <= 5'h00;
          end else begin
            tq_cnt_reg <= tq_cnt_reg + 5'h01;
          end
        end
        cbt_pkg::SEG_PH1: begin
          if (ph1_end) begin
            state_reg  <= cbt_pkg::SEG_PH2;
            tq_cnt_reg <= 5'h00;
          end else begin
            tq_cnt_reg <= tq_cnt_reg + 5'h01;
          end
        end
        default: begin
          if (ph2_end) begin
            state_reg  <= cbt_pkg::SEG_SYNC;
            tq_cnt_reg <= 5'h00;
          end else begin
            tq_cnt_reg <= tq_cnt_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // per-bit synchronisation bookkeeping
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_reg     <= 4'h0;
      shr_reg     <= 4'h0;
      hs_done_reg <= 1'b0;
      rs_done_reg <= 1'b0;
    end else if (restart) begin
      ext_reg     <= 4'h0;
      shr_reg     <= 4'h0;
      hs_done_reg <= hard_sync_now;
      rs_done_reg <= early_restart;
    end else if (bit_end) begin
      ext_reg     <= 4'h0;
      shr_reg     <= 4'h0;
      hs_done_reg <= 1'b0;
      rs_done_reg <= 1'b0;
    end else begin
      if (do_late) begin
        ext_reg <= (late_err > {1'b0, jw_len}) ? jw_len : late_err[3:0];
      end
      if (do_short) begin
        shr_reg <= jw_len;
      end
      if (resync_ok) begin
        rs_done_reg <= 1'b1;
      end
    end
  end

  // bus level history at half-quantum points
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
      hist_reg    <= 2'b11;
    end else begin
      rx_prev_reg <= can_rx;
      if (half_tick) begin
        hist_reg <= {hist_reg[0], can_rx};
      end
    end
  end

  // event outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_reg <= '{sample_bit: 1'b1, sample_strobe: 1'b0, bit_start: 1'b0, hard_sync: 1'b0, resync: 1'b0};
    end else begin
      if (sample_evt) begin
        ev_reg.sample_bit <= sample_val;
      end
      ev_reg.sample_strobe <= sample_evt;
      ev_reg.bit_start     <= restart || bit_end;
      ev_reg.hard_sync     <= hard_sync_now;
      ev_reg.resync        <= do_late || do_short || early_restart;
    end
  end

  assign reg_rdata = rdata_reg;
  assign bit_event = ev_reg;

  // helper: clocks since the last quantum tick
  logic [7:0] tq_gap_reg;
  logic       gap_void_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tq_gap_reg   <= 8'h00;
      gap_void_reg <= 1'b1;
    end else if (restart || reg_wr) begin
      tq_gap_reg   <= 8'h00;
      gap_void_reg <= 1'b1;
    end else if (tq_tick) begin
      tq_gap_reg   <= 8'h00;
      gap_void_reg <= 1'b0;
    end else begin
      tq_gap_reg   <= tq_gap_reg + 8'h01;
    end
  end

  a_tq_period: assert property (@(posedge core_clk) disable iff (rst)
    (tq_tick && !gap_void_reg) |-> (tq_gap_reg == {1'b0, cfg.baud_prescale, 1'b1}))
    else $error("quantum period wrong");

  a_sync_one_tq: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == cbt_pkg::SEG_SYNC && tq_tick && !restart) |=> (state_reg == cbt_pkg::SEG_PROP))
    else $error("sync segment not one quantum");

  a_prop_seg_len: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == cbt_pkg::SEG_PH1 && $past(state_reg) == cbt_pkg::SEG_PROP)
    |-> ($past(tq_cnt_reg) == {2'b00, $past(cfg.prop_segment_len)}))
    else $error("propagation segment length wrong");

  a_ph1_seg_len: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == cbt_pkg::SEG_PH2 && $past(state_reg) == cbt_pkg::SEG_PH1)
    |-> ($past(tq_cnt_reg) == ({2'b00, $past(cfg.phase1_len)} + {1'b0, $past(ext_reg)})))
    else $error("phase1 length wrong");

  a_sample_at_end: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == cbt_pkg::SEG_PH2 && $past(state_reg) == cbt_pkg::SEG_PH1) |-> ev_reg.sample_strobe)
    else $error("no sample at end of phase1");

  a_single_sample: assert property (@(posedge core_clk) disable iff (rst)
    (ev_reg.sample_strobe && !$past(cfg.triple_sample_sel)) |-> (ev_reg.sample_bit == $past(can_rx)))
    else $error("single sample value wrong");

  a_triple_vote: assert property (@(posedge core_clk) disable iff (rst)
    (ev_reg.sample_strobe && $past(cfg.triple_sample_sel))
    |-> (ev_reg.sample_bit == (($past(can_rx) & $past(hist_reg[0])) | ($past(can_rx) & $past(hist_reg[1]))
                               | ($past(hist_reg[0]) & $past(hist_reg[1])))))
    else $error("majority vote wrong");

  a_hard_restart: assert property (@(posedge core_clk) disable iff (rst)
    hard_sync_now |=> (state_reg == cbt_pkg::SEG_SYNC && tq_cnt_reg == 5'h00 && presc_cnt_reg == 6'h00
                       && ev_reg.hard_sync && hs_done_reg))
    else $error("hard sync did not restart bit");

  a_no_resync_hs: assert property (@(posedge core_clk) disable iff (rst)
    (hs_done_reg && fall_edge && !bus_idle) |=> !ev_reg.resync)
    else $error("resync inside hard-synced bit");

  a_jump_bound: assert property (@(posedge core_clk) disable iff (rst)
    (ext_reg <= jw_len) && (shr_reg <= jw_len))
    else $error("adjustment exceeds jump width");

endmodule

/* File: tb/cbt_node_model.sv */
`timescale 1ns/1ns
module cbt_node_model (
  // clock
  input  wire logic core_clk,
  // bus level, recessive high
  output logic      can_rx
);
  initial can_rx = 1'h1;

  // one frame; a delay from bit lk on shifts the rest, as a slow node would
  task automatic send(input logic [15:0] bits, input int nb, len, lk, ld, gl);
    int   t;
    int   tt;
    logic lvl;
    for (t = 0; t < nb * len + ld; t++) begin // whole bits of len clocks
      tt = (lk > 0 && t >= lk * len + ld) ? t - ld : t;
      lvl = (lk > 0 && t >= lk * len && t < lk * len + ld) ? bits[lk - 1] : bits[tt / len];
      can_rx <= lvl ^ (t == gl);
      @(posedge core_clk);
    end
    // released bus is pulled recessive
    can_rx <= 1'h1;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic                core_clk   = 1'h0;
  logic                rst        = 1'h1;
  logic [3:0]          reg_addr   = 4'h0;
  logic [15:0]         reg_wdata  = 16'h0;
  logic                reg_wr     = 1'h0;
  logic                reg_rd     = 1'h0;
  logic [15:0]         reg_rdata;
  logic                can_rx;
  logic                bus_idle   = 1'h1;
  cbt_pkg::cbt_event_t bit_event;
  int                  n_mismatch = 0;
  int                  cmp_count  = 0;
  int                  cyc        = 0;
  int                  h          = 0;
  int                  n_edge     = 0;
  int                  ph2_cyc    = 0;
  int                  s_cyc      = -1;
  int                  exp_len    = 0;
  logic                hs_seen    = 1'h0;
  logic                watch      = 1'h0;
  logic                rd_d       = 1'h0;
  logic [15:0]         rq[$];
  logic [15:0]         rm[$];
  int                  sq_t[$];
  logic                sq_v[$];
  logic [15:0]         r1;

  // 10 ns bench clock; a real system keeps the input clock lower
  always #5 core_clk = ~core_clk;

  cbt_bit_timing i_cbt_bit_timing (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx(can_rx), .bus_idle(bus_idle),
    .bit_event(bit_event));
  cbt_node_model i_cbt_node_model (.core_clk(core_clk), .can_rx(can_rx));

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_time(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      n_mismatch++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one bus cycle per call, so calls run back to back with no gap
  task automatic op(input logic w, r, input logic [3:0] a, input logic [15:0] d, e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) rq.push_back(e);
    // status fields that follow the running bit are masked
    if (r) rm.push_back((a == cbt_pkg::ADDR_STATUS) ? 16'he0f3 : 16'hffff);
    @(posedge core_clk);
  endtask

  // late-edge model assumes a jump width of one quantum
  task automatic frame(input int p, jw, pr, p1, sel, p2, tr, input logic [15:0] bits, input int nb, lk, ld, gl);
    int          q;
    int          sp;
    int          ph2;
    int          k;
    int          dsh;
    int          ext;
    int          psh;
    logic [15:0] c2;
    q = 2 * (p + 1);
    ph2 = sel ? p2 + 1 : (p1 + 1 > 2 ? p1 + 1 : 2);
    sp = (pr + p1 + 3) * q;
    exp_len = sp + ph2 * q;
    ph2_cyc = ph2 * q;
    c2 = {5'h0, 3'(p2), 1'(sel), 1'(tr), 3'(p1), 3'(pr)};
    op(1'h1, 1'h0, cbt_pkg::ADDR_CFG_ONE, {8'h0, 2'(jw), 6'(p)}, 16'h0);
    op(1'h1, 1'h0, cbt_pkg::ADDR_CFG_TWO, c2, 16'h0);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_TWO, 16'h0, c2);
    repeat (4) op(1'h0, 1'h0, 4'h0, 16'h0, 16'h0);
    dsh = 0;
    for (k = 0; k < nb; k++) begin
      psh = (lk > 0 && k >= lk) ? ld : 0;
      ext = (k > 0 && bits[k - 1] && !bits[k] && psh - dsh - 1 >= q) ? q : 0;
      sq_t.push_back(sp + k * exp_len + dsh + ext);
      sq_v.push_back(bits[k] ^ (gl == k * exp_len + sp && tr == 0));
      dsh += ext;
    end
    hs_seen = 1'h0;
    watch = 1'h1;
    n_edge = cyc + 1;
    fork
      i_cbt_node_model.send(bits, nb, exp_len, lk, ld, gl);
      begin
        repeat (2) @(posedge core_clk);
        bus_idle <= 1'h0;
      end
    join
    k = 0;
    while (sq_t.size() > 0 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    chk_time("samples_left", 0, sq_t.size());
    sq_t.delete();
    sq_v.delete();
    watch = 1'h0;
    bus_idle <= 1'h1;
  endtask

  always @(posedge core_clk) rd_d <= reg_rd;

  always @(negedge core_clk) begin
    cyc++;
    if (rd_d && rq.size() > 0) chk_val("rdata", rq.pop_front(), reg_rdata & rm.pop_front());
    else if (!rd_d) chk_val("rdata_idle", 16'h0, reg_rdata);
    if (watch && bit_event.hard_sync === 1'h1) begin
      chk_val("hard_sync_once", 16'h0, {15'h0, hs_seen});
      chk_time("hard_sync_lat", n_edge + 1, cyc);
      h = cyc;
      s_cyc = -1;
      hs_seen = 1'h1;
    end
    if (watch && hs_seen && bit_event.bit_start === 1'h1 && s_cyc >= 0) begin
      chk_time("bit_start_at", s_cyc + ph2_cyc, cyc);
    end
    if (watch && hs_seen && bit_event.resync === 1'h1 && cyc < h + exp_len) chk_val("resync_hard_bit", 16'h0, 16'h1);
    if (watch && hs_seen && bit_event.sample_strobe === 1'h1 && sq_t.size() > 0) begin
      chk_time("sample_at", sq_t.pop_front(), cyc - h);
      s_cyc = cyc;
      chk_val("sample_bit", {15'h0, sq_v.pop_front()}, {15'h0, bit_event.sample_bit});
    end
  end

  initial begin
    #200000;
    chk_time("watchdog", 0, 1);
    conclude();
  end

  initial begin
    void'($urandom(32'h8ed05ea1));
    repeat (16) @(posedge core_clk);
    chk_val("event_rst", 16'h10, {11'h0, bit_event});
    rst <= 1'h0;
    @(posedge core_clk);
    r1 = 16'($urandom);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_ONE, 16'h0, cbt_pkg::CFG_ONE_RST);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_TWO, 16'h0, cbt_pkg::CFG_TWO_RST);
    op(1'h1, 1'h0, cbt_pkg::ADDR_CFG_ONE, r1, 16'h0);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_ONE, 16'h0, r1 & 16'h00ff);
    op(1'h1, 1'h0, 4'h8, ~r1, 16'h0);
    op(1'h0, 1'h1, 4'h8, 16'h0, 16'h0);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_ONE, 16'h0, r1 & 16'h00ff);
    op(1'h1, 1'h0, cbt_pkg::ADDR_CFG_TWO, r1, 16'h0);
    op(1'h0, 1'h1, cbt_pkg::ADDR_CFG_TWO, 16'h0, r1 & 16'h07ff);
    op(1'h0, 1'h1, cbt_pkg::ADDR_STATUS, 16'h0, 16'h0003);
    op(1'h0, 1'h0, 4'h0, 16'h0, 16'h0);
    // settings keep prop+ph1>=ph2, jump<ph2, 8..12 quanta
    frame(0, 0, 2, 2, 0, 0, 0, 16'h000a, 6, 2, 5, 16);
    frame(1, 1, 1, 1, 1, 2, 1, 16'h0002, 3, 0, 0, 84);
    frame(1, 1, 1, 1, 1, 2, 0, 16'h0002, 3, 0, 0, 84);
    r1 = 16'($urandom);
    frame(2, 0, 0, 4, 0, 0, 0, {r1[15:1], 1'h0}, 7, 0, 0, -1);
    frame(63, 0, 7, 0, 0, 0, 0, 16'h0002, 2, 0, 0, -1);
    conclude();
  end
endmodule
